// ===== hdl/tmo_pkg.sv
// Behaviour
// RQ1: count up sixteen bits, wrap to zero
// RQ2: wrap sets sticky overflow flag bit 0
// RQ3: overflow irq forwarded only when enabled
// RQ4: special trigger match clears count, starts conversion
// RQ5: trigger reset never sets overflow flag
// RQ6: trigger reset only in synchronous modes
// RQ7: software write beats trigger reset
// RQ8: compare pair acts as period
// RQ9: wide mode maps high address to buffer
// RQ10: low read snapshots high into buffer
// RQ11: low write loads high from buffer
// RQ12: wide mode hides live high byte
// RQ13: low write clears prescaler, high write not
// RQ14: software sets high msb only, keeps low
// RQ15: software picks async mode, enables irq, oscillator
// RQ16: narrow mode gives direct high byte access
package tmo_pkg;

    // =========================================
    // register offsets
    localparam logic [3:0] ADDR_COUNT_LOW  = 4'h0;
    localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1;
    localparam logic [3:0] ADDR_CONTROL    = 4'h2;
    localparam logic [3:0] ADDR_IRQ_FLAGS  = 4'h3;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;
    localparam logic [3:0] ADDR_CMP_LOW    = 4'h5;
    localparam logic [3:0] ADDR_CMP_HIGH   = 4'h6;
    localparam logic [3:0] ADDR_CMP_MODE   = 4'h7;

    // =========================================
    // control and interrupt field positions
    localparam int CTL_WIDE_BIT  = 7;
    localparam int CTL_ASYNC_BIT = 2;
    localparam int CTL_EXT_BIT   = 1;
    localparam int CTL_ON_BIT    = 0;
    localparam int CTL_PS_LSB    = 4;
    localparam int IRQ_OVF_BIT   = 0;
    localparam int IRQ_CMP_BIT   = 1;

    // =========================================
    // reset values and codes
    localparam logic [7:0]  CONTROL_RESET  = 8'h00;
    localparam logic [7:0]  IRQ_EN_RESET   = 8'h00;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [15:0] COUNT_MAX      = 16'hffff;
    localparam logic [15:0] CMP_RESET      = 16'hffff;
    localparam logic [3:0]  CMP_MODE_RESET = 4'h0;
    localparam logic [3:0]  MODE_SPECIAL   = 4'hb;
    localparam logic [7:0]  PRESCALE_RESET = 8'h00;

endpackage : tmo_pkg

// ===== hdl/tmo_prescaler.sv
module tmo_prescaler
    import tmo_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // control
    input  wire logic       run,
    input  wire logic       clear,
    input  wire logic [1:0] ratio_sel,
    // output
    output logic            tick
);
    logic [7:0] count_reg;
    logic [7:0] limit;

    // ratios 1, 2, 4, 8
    always_comb
    begin
        limit = 8'h00;
        case (ratio_sel)
            2'h0:    limit = 8'h00;
            2'h1:    limit = 8'h01;
            2'h2:    limit = 8'h03;
            default: limit = 8'h07;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || clear)
            count_reg <= PRESCALE_RESET;   // [RQ13]
        else if (run)
            count_reg <= (count_reg >= limit) ? PRESCALE_RESET : count_reg + 8'h01;
    end

    assign tick = run && !clear && (count_reg >= limit);

endmodule : tmo_prescaler

// ===== hdl/tmo_edge_sync.sv
module tmo_edge_sync
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    // input level
    input  wire logic level_in,
    // rising-edge pulse
    output logic      rise
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;

    // second stage alone reads the first
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= level_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    assign rise = stage2_reg && !stage3_reg;

endmodule : tmo_edge_sync

// ===== hdl/tmo_timer.sv
// The plain strobed port and the address map were left to the implementer.
module tmo_timer
    import tmo_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_rdata,
    // external count input and converter enable
    input  wire logic       ext_count_in,
    input  wire logic       converter_enable,
    // outputs
    output logic            conversion_start,
    output logic            irq
);
    logic [15:0] count_reg;
    logic [7:0]  high_buffer_reg;
    logic [7:0]  timer_control_reg;
    logic [7:0]  irq_flags_reg;
    logic [7:0]  irq_enables_reg;
    logic [15:0] compare_value_pair_reg;
    logic [3:0]  compare_mode_field_reg;
    logic [7:0]  rdata_reg;
    logic        conv_reg;
    logic        ext_rise;
    logic        tick;
    logic        clk_src;
    logic        wide;
    logic        async_mode;
    logic        wr_low;
    logic        wr_high;
    logic        rd_low;
    logic        inc;
    logic        wrap;
    logic        match;
    logic        trig_reset;

    // =========================================
    // decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    assign wide       = timer_control_reg[CTL_WIDE_BIT];
    assign async_mode = timer_control_reg[CTL_ASYNC_BIT];
    assign wr_low     = reg_write && hit(reg_addr, ADDR_COUNT_LOW);
    assign wr_high    = reg_write && hit(reg_addr, ADDR_COUNT_HIGH);
    assign rd_low     = reg_read && hit(reg_addr, ADDR_COUNT_LOW);

    // =========================================
    // clock source and prescaler
    tmo_edge_sync i_tmo_edge_sync (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .level_in (ext_count_in),
        .rise     (ext_rise)
    );

    // bit 1 selects external edges; internal clock otherwise
    assign clk_src = timer_control_reg[CTL_EXT_BIT] ? ext_rise : 1'b1;

    tmo_prescaler i_tmo_prescaler (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .run       (timer_control_reg[CTL_ON_BIT] && clk_src),
        .clear     (wr_low),                                  // [RQ13]
        .ratio_sel (timer_control_reg[CTL_PS_LSB +: 2]),
        .tick      (tick)
    );

    // =========================================
    // counter
    assign inc   = tick;
    assign wrap  = inc && (count_reg == COUNT_MAX);            // [RQ1]
    assign match = (compare_mode_field_reg == MODE_SPECIAL)
                && (count_reg == compare_value_pair_reg);      // [RQ4] [RQ8]
    // async mode cannot be trusted to reset, so it is simply not done
    assign trig_reset = match && !async_mode;                  // [RQ6]

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            count_reg <= COUNT_RESET;
        else if (wr_low && wide)
            count_reg <= {high_buffer_reg, reg_wdata};         // [RQ11] [RQ7]
        else if (wr_low)
            count_reg <= {count_reg[15:8], reg_wdata};         // [RQ7]
        // low byte keeps counting, so a high write never costs a tick
        else if (wr_high && !wide)
            count_reg <= {reg_wdata, count_reg[7:0] + {7'h00, inc}}; // [RQ16] [RQ7]
        else if (trig_reset)
            count_reg <= COUNT_RESET;                          // [RQ4]
        else if (inc)
            count_reg <= count_reg + 16'h0001;                 // [RQ1]
    end

    // =========================================
    // high byte buffer
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            high_buffer_reg <= 8'h00;
        else if (wr_high && wide)
            high_buffer_reg <= reg_wdata;                      // [RQ9] [RQ12]
        else if (rd_low && wide)
            high_buffer_reg <= count_reg[15:8];                // [RQ10]
    end

    // =========================================
    // control and compare registers
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            timer_control_reg <= CONTROL_RESET;
        else if (reg_write && hit(reg_addr, ADDR_CONTROL))
            timer_control_reg <= reg_wdata;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            irq_enables_reg <= IRQ_EN_RESET;
        else if (reg_write && hit(reg_addr, ADDR_IRQ_ENABLE))
            irq_enables_reg <= reg_wdata;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            compare_value_pair_reg <= CMP_RESET;
            compare_mode_field_reg <= CMP_MODE_RESET;
        end
        else if (reg_write)
        begin
            if (hit(reg_addr, ADDR_CMP_LOW))
                compare_value_pair_reg[7:0] <= reg_wdata;
            if (hit(reg_addr, ADDR_CMP_HIGH))
                compare_value_pair_reg[15:8] <= reg_wdata;
            if (hit(reg_addr, ADDR_CMP_MODE))
                compare_mode_field_reg <= reg_wdata[3:0];
        end
    end

    // =========================================
    // interrupt flags: write one clears, set wins
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            irq_flags_reg <= 8'h00;
        else
        begin
            if (reg_write && hit(reg_addr, ADDR_IRQ_FLAGS))
                irq_flags_reg <= irq_flags_reg & ~reg_wdata;
            // a trigger reset is not a wrap, so it never sets this
            if (wrap && !wr_low && !(wr_high && !wide) && !trig_reset)
                irq_flags_reg[IRQ_OVF_BIT] <= 1'b1;            // [RQ2] [RQ5]
            if (trig_reset)
                irq_flags_reg[IRQ_CMP_BIT] <= 1'b1;
        end
    end

    assign irq = |(irq_flags_reg & irq_enables_reg);           // [RQ3]

    // =========================================
    // conversion start pulse
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            conv_reg <= 1'b0;
        else
            conv_reg <= trig_reset && converter_enable;        // [RQ4]
    end

    assign conversion_start = conv_reg;

    // =========================================
    // read data, one cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            rdata_reg <= 8'h00;
        else if (reg_read)
        begin
            case (reg_addr)
                ADDR_COUNT_LOW:  rdata_reg <= count_reg[7:0];
                ADDR_COUNT_HIGH: rdata_reg <= wide ? high_buffer_reg
                                                   : count_reg[15:8]; // [RQ12] [RQ16]
                ADDR_CONTROL:    rdata_reg <= timer_control_reg;
                ADDR_IRQ_FLAGS:  rdata_reg <= irq_flags_reg;
                ADDR_IRQ_ENABLE: rdata_reg <= irq_enables_reg;
                ADDR_CMP_LOW:    rdata_reg <= compare_value_pair_reg[7:0];
                ADDR_CMP_HIGH:   rdata_reg <= compare_value_pair_reg[15:8];
                ADDR_CMP_MODE:   rdata_reg <= {4'h0, compare_mode_field_reg};
                default:         rdata_reg <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_reg;

endmodule : tmo_timer

// ===== sim/tmo_timer_assertions.sv
module tmo_timer_checker
    import tmo_pkg::*;
(
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       reset_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // events
    input wire logic       converter_enable,
    input wire logic       conversion_start,
    input wire logic       irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    logic [1:0] en_q;
    logic       wide_q;

    // =========================================
    // shadow of software writes
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            en_q   <= 2'h0;
            wide_q <= 1'b0;
        end
        else if (reg_write && reg_addr == ADDR_IRQ_ENABLE)
            en_q <= reg_wdata[1:0];
        else if (reg_write && reg_addr == ADDR_CONTROL)
            wide_q <= reg_wdata[CTL_WIDE_BIT];
    end

    sequence rd_at(logic [3:0] a);
        reg_read && reg_addr == a;
    endsequence

    // =========================================
    // properties
    rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    unmapped_read_a: assert property (reg_read && reg_addr[3] |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    en_readback_a: assert property (rd_at(ADDR_IRQ_ENABLE) |=> reg_rdata[1:0] == $past(en_q))
        else $error("enable readback wrong");
    ctl_readback_a: assert property (rd_at(ADDR_CONTROL) |=> reg_rdata[CTL_WIDE_BIT] == $past(wide_q))
        else $error("wide bit readback wrong");
    irq_needs_en_a: assert property (irq |-> en_q != 2'h0)
        else $error("irq without enable");
    irq_mask_a: assert property (reg_write && reg_addr == ADDR_IRQ_ENABLE && reg_wdata == 8'h00 |=> !irq)
        else $error("irq after masking");
    flag_irq_a: assert property (rd_at(ADDR_IRQ_FLAGS) ##0 !irq |=> (reg_rdata[1:0] & $past(en_q)) == 2'h0)
        else $error("enabled flag set but irq low");
    conv_cause_a: assert property (conversion_start |-> $past(converter_enable) || $past(converter_enable, 2))
        else $error("conversion start while converter off");
endmodule : tmo_timer_checker

bind tmo_timer tmo_timer_checker i_tmo_timer_checker (
    .ref_clk          (ref_clk),
    .reset_n          (reset_n),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_write        (reg_write),
    .reg_read         (reg_read),
    .reg_rdata        (reg_rdata),
    .converter_enable (converter_enable),
    .conversion_start (conversion_start),
    .irq              (irq)
);

// ===== sim/tmo_timer_tb.sv
module tmo_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tmo_pkg::*;

    logic       ref_clk          = 1'b0;
    logic       reset_n          = 1'b0;
    logic [3:0] reg_addr         = 4'h0;
    logic [7:0] reg_wdata        = 8'h00;
    logic       reg_write        = 1'b0;
    logic       reg_read         = 1'b0;
    logic       converter_enable = 1'b0;
    logic       ext_count_in     = 1'b0;
    logic [7:0] reg_rdata;
    logic       conversion_start;
    logic       irq;
    logic [7:0] rv;
    int         n_mismatch       = 0;
    int         checks_done      = 0;
    int         n_conv           = 0;
    int         cyc              = 0;

    // one second of a watch crystal, one count per clock here
    localparam int RTC_TICKS     = 32768;

    always #5 ref_clk = ~ref_clk;

    tmo_timer i_tmo_timer (
        .ref_clk          (ref_clk),
        .reset_n          (reset_n),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_write        (reg_write),
        .reg_read         (reg_read),
        .reg_rdata        (reg_rdata),
        .ext_count_in     (ext_count_in),
        .converter_enable (converter_enable),
        .conversion_start (conversion_start),
        .irq              (irq)
    );

    // =========================================
    // helpers
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    always @(posedge ref_clk)
    begin
        cyc++;
        if (conversion_start === 1'b1)
            n_conv++;
        if (cyc == 40000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("MISMATCH %s exp %h got %h", n, e, g);
            n_mismatch++;
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask : rd

    task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string n);
        rd(a);
        chk(n, e, rv);
    endtask : rdc

    // bounded wait, irq settles after the write edge
    task automatic wait_irq(input logic v);
        int i;
        i = 0;
        #1;
        while (irq !== v && i < 40)
        begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        chk("irq", {7'h00, v}, {7'h00, irq});
    endtask : wait_irq

    // =========================================
    // scenarios
    task automatic t_reset();
        rdc(ADDR_CONTROL, CONTROL_RESET, "control");
        rdc(ADDR_IRQ_ENABLE, IRQ_EN_RESET, "enables");
        rdc(ADDR_CMP_LOW, CMP_RESET[7:0], "cmp_low");
        rdc(ADDR_COUNT_LOW, COUNT_RESET[7:0], "count_low");
        wr(4'h9, 8'h5a);
        rdc(4'h9, 8'h00, "unmapped");
    endtask : t_reset

    task automatic t_wrap();
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_COUNT_HIGH, 8'hff);
        wr(ADDR_COUNT_LOW, 8'hf0);
        wr(ADDR_CONTROL, 8'h01);
        wait_irq(1'b1);
        wr(ADDR_CONTROL, 8'h00);
        rdc(ADDR_COUNT_HIGH, 8'h00, "high_wrapped");
        wr(ADDR_IRQ_ENABLE, 8'h00);
        wait_irq(1'b0);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wait_irq(1'b1);
        wr(ADDR_IRQ_FLAGS, 8'h03);
        wait_irq(1'b0);
    endtask : t_wrap

    task automatic t_wide();
        wr(ADDR_COUNT_HIGH, 8'h12);
        wr(ADDR_COUNT_LOW, 8'h34);
        rdc(ADDR_COUNT_HIGH, 8'h12, "high_narrow");
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_COUNT_HIGH, 8'h56);
        rdc(ADDR_COUNT_HIGH, 8'h56, "high_buffer");
        wr(ADDR_CONTROL, 8'h00);
        rdc(ADDR_COUNT_HIGH, 8'h12, "high_hidden");
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_COUNT_HIGH, 8'h9a);
        wr(ADDR_COUNT_LOW, 8'hbc);
        wr(ADDR_CONTROL, 8'h00);
        rdc(ADDR_COUNT_HIGH, 8'h9a, "high_loaded");
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_COUNT_HIGH, 8'h77);
        rd(ADDR_COUNT_LOW);
        rdc(ADDR_COUNT_HIGH, 8'h9a, "high_snapshot");
        wr(ADDR_CONTROL, 8'h00);
    endtask : t_wide

    task automatic t_trig();
        int c0;
        int i;
        wr(ADDR_CMP_LOW, 8'h10);
        wr(ADDR_CMP_HIGH, 8'h00);
        wr(ADDR_CMP_MODE, {4'h0, MODE_SPECIAL});
        wr(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_COUNT_LOW, 8'h00);
        @(posedge ref_clk);
        converter_enable <= 1'b1;
        c0 = n_conv;
        i = 0;
        wr(ADDR_CONTROL, 8'h01);
        while (n_conv < c0 + 3 && i < 80)
        begin
            @(posedge ref_clk);
            i++;
        end
        wr(ADDR_CONTROL, 8'h00);
        chk("conv_starts", 8'h01, {7'h00, n_conv >= c0 + 3});
        rd(ADDR_IRQ_FLAGS);
        chk("trig_flags", 8'h02, rv & 8'h03);
        rd(ADDR_COUNT_LOW);
        chk("period", 8'h01, {7'h00, rv <= 8'h10});
        rdc(ADDR_COUNT_HIGH, 8'h00, "period_high");
        @(posedge ref_clk);
        converter_enable <= 1'b0;
        c0 = n_conv;
        wr(ADDR_CONTROL, 8'h01);
        repeat (40) @(posedge ref_clk);
        chk("conv_off", 8'h01, {7'h00, n_conv == c0});
        wr(ADDR_CONTROL, 8'h05);
        repeat (40) @(posedge ref_clk);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_COUNT_LOW);
        chk("async_no_reset", 8'h01, {7'h00, rv > 8'h10});
        // trigger lands on the wrap value: still no overflow flag
        wr(ADDR_IRQ_FLAGS, 8'h03);
        wr(ADDR_CMP_LOW, 8'hff);
        wr(ADDR_CMP_HIGH, 8'hff);
        wr(ADDR_COUNT_HIGH, 8'hff);
        wr(ADDR_COUNT_LOW, 8'hf0);
        wr(ADDR_CONTROL, 8'h01);
        repeat (40) @(posedge ref_clk);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_IRQ_FLAGS);
        chk("trig_at_max", 8'h02, rv & 8'h03);
    endtask : t_trig

    task automatic t_ext();
        wr(ADDR_CMP_MODE, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_CONTROL, 8'h03);
        repeat (5)
        begin
            @(posedge ref_clk);
            ext_count_in <= 1'b1;
            repeat (2) @(posedge ref_clk);
            ext_count_in <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        repeat (6) @(posedge ref_clk);
        wr(ADDR_CONTROL, 8'h00);
        rdc(ADDR_COUNT_LOW, 8'h05, "ext_edges");
    endtask : t_ext

    // watch-crystal use: async mode, irq on, only the high msb is touched
    task automatic t_rtc();
        int c1;
        int c2;
        int i;
        wr(ADDR_COUNT_HIGH, 8'hff);
        wr(ADDR_COUNT_LOW, 8'hf0);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_CONTROL, 8'h05);
        wait_irq(1'b1);
        c1 = cyc;
        wr(ADDR_IRQ_FLAGS, 8'h01);
        rd(ADDR_COUNT_HIGH);
        wr(ADDR_COUNT_HIGH, rv | 8'h80);
        i = 0;
        #1;
        while (irq !== 1'b1 && i < RTC_TICKS + 64)
        begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        c2 = cyc;
        wr(ADDR_CONTROL, 8'h00);
        chk("rtc_period", 8'h01, {7'h00, (c2 - c1) == RTC_TICKS});
    endtask : t_rtc

    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_wrap();
        t_wide();
        t_trig();
        t_ext();
        t_rtc();
        report_and_stop();
    end
endmodule : tmo_timer_tb
